// ---- hdl/hsc_host.sv ----
// Terminal-side controller: payload FIFO and APDU sequencer
module hsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Pointers wrap naturally, so DEPTH must be a power of two
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  assign in_ready  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rd_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ff] <= in_data;
    end
  end
endmodule

// Overview of operation
// [R1] Start payload holds four mandatory TLVs
// [R2] Cipher byte bits pick algorithm, b4-b7 reserved
// [R3] Exactly one bit in each selector byte
// [R4] Integrity byte bits pick mechanism, b4-b7 reserved
// [R5] Association id and start MAC 16 bytes
// [R6] Container size not above card maximum
// [R7] Start response tag 53, session b8-b7
// [R8] Session number bound to container size
// [R9] Bad terminate MAC answers 98 62
// [R10] Missing association succeeds, failure reports error
// [R11] Terminate P1 04, P2 80/A0, tag 73
// [R12] Master alone or connections of one master
// [R13] Association TLV length 32, id, MAC
// [R14] P1 b3 picks direction, b2 header only
// [R15] Up to four interleaved transfer sessions
// [R16] P2 gives remaining blocks to card
// [R17] Card may answer 92 XX, more pending
// [R18] Final block answered data transaction ongoing
// [R19] Non-last outgoing block flags more pending
// [R20] Terminal abort keeps association, drops data
// [R21] Proactive pending allows 91 XX interleave
// [R22] Outgoing case omits Lc, gives Le
// [R23] P1 session b8-b7, data b3, abort b2, retransmit b1
// [R24] SW2 fields: retransmit, proactive, session, more
// [R25] 6A 84 aborts the transfer session
// [R26] Card rejects malformed start commands
module hsc_host
  import hsc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire hsc_cmd_t    cmd,
  output logic             cmd_err,
  input  wire logic        pay_valid,
  output logic             pay_ready,
  input  wire logic [7:0]  pay_data,
  input  wire logic [7:0]  card_max_size,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic      [7:0]  tx_data,
  output logic             tx_last,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_is_sw,
  output logic             resp_valid,
  output logic      [7:0]  resp_data,
  output logic             done,
  output hsc_sts_t         sts,
  output logic      [3:0]  sess_open,
  output logic      [3:0]  xfer_busy
);
  hsc_state_t st_ff, nxt_st;
  hsc_cmd_t   cmd_ff, nxt_cmd;
  hsc_sts_t   sts_ff, nxt_sts;
  logic [7:0] idx_ff, nxt_idx, sw1_ff, nxt_sw1, rxi_ff, nxt_rxi, rd_ff, nxt_rd;
  logic [7:0] txd_ff, nxt_txd, pend_ff, nxt_pend;
  logic [7:0] size_ff [NUM_SESS];
  logic [7:0] nxt_size [NUM_SESS];
  logic [3:0] open_ff, nxt_open, busy_ff, nxt_busy;
  logic [1:0] rsess_ff, nxt_rsess;
  logic       swh_ff, nxt_swh, rgot_ff, nxt_rgot, txv_ff, nxt_txv, txl_ff, nxt_txl;
  logic       err_ff, nxt_err, rv_ff, nxt_rv, done_ff, nxt_done;
  logic [7:0] p1, p2, p3, blen, cbyte, cur_byte, f_data;
  logic       from_fifo, need, f_valid, adv, last_hdr, cmd_ok, sw_fire, take;
  logic [15:0] sw_word;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  hsc_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (pay_valid),
    .in_ready  (pay_ready),
    .in_data   (pay_data),
    .out_valid (f_valid),
    .out_ready (adv && need),
    .out_data  (f_data)
  );

  assign cmd_ready  = (st_ff == ST_IDLE);
  assign cmd_err    = err_ff;
  assign tx_valid   = txv_ff;
  assign tx_data    = txd_ff;
  assign tx_last    = txl_ff;
  assign resp_valid = rv_ff;
  assign resp_data  = rd_ff;
  assign done       = done_ff;
  assign sts        = sts_ff;
  assign sess_open  = open_ff;
  assign xfer_busy  = busy_ff;
  assign need       = (st_ff == ST_BODY) && from_fifo;
  assign adv        = (st_ff == ST_HDR || st_ff == ST_BODY) && (!txv_ff || tx_ready)
                      && (!need || f_valid);
  assign sw_fire    = (st_ff == ST_RX) && rx_valid && rx_is_sw && swh_ff;
  assign sw_word    = {sw1_ff, rx_data};
  assign take       = (st_ff == ST_IDLE) && cmd_valid && cmd_ok;
  assign last_hdr   = (idx_ff == HDR_P3) ||
                      (idx_ff == HDR_P2 && cmd_ff.op == OP_XACT && cmd_ff.abort); // [R14]

  // Acceptance check: malformed start and transact orders never reach the card
  always_comb begin
    case (cmd.op)
      OP_START: cmd_ok = $onehot(cmd.cipher_algorithm_byte) &&
                         $onehot(cmd.integrity_mechanism_byte) && // [R3]
                         ((cmd.cipher_algorithm_byte & SEL_RSVD_MASK) == 8'h00) && // [R2]
                         ((cmd.integrity_mechanism_byte & SEL_RSVD_MASK) == 8'h00) && // [R4]
                         (cmd.size != 8'h00) && (cmd.size <= card_max_size); // [R6]
      OP_XACT:  cmd_ok = open_ff[cmd.sess] && (cmd.abort ||
                         (!cmd.data_in ? (cmd.blocks == 8'h00) :
                          (cmd.len != 8'h00 && cmd.len <= XDATA_MAX &&
                           cmd.len <= size_ff[cmd.sess]))); // [R8] [R15]
      default:  cmd_ok = 1'b1;
    endcase
  end

  // APDU byte generator
  always_comb begin
    case (cmd_ff.op)
      OP_START: p1 = P1_START;
      OP_TERM:  p1 = P1_TERM; // [R11]
      OP_FETCH: p1 = cmd_ff.fetch_term ? P1_TERM : P1_START;
      default:  p1 = {cmd_ff.sess, 3'b000, cmd_ff.data_in, cmd_ff.abort, cmd_ff.retx}; // [R23]
    endcase
    case (cmd_ff.op)
      OP_FETCH: p2 = P2_RESP; // [R11]
      OP_XACT:  p2 = cmd_ff.blocks; // [R16]
      default:  p2 = P2_CMD;
    endcase
    case (cmd_ff.op)
      OP_START: p3 = START_LC;
      OP_TERM:  p3 = TERM_LC;
      OP_XACT:  p3 = cmd_ff.data_in ? cmd_ff.len + XDATA_HDR : cmd_ff.len; // [R22]
      default:  p3 = cmd_ff.len;
    endcase
    case (cmd_ff.op)
      OP_START: blen = START_LEN;
      OP_TERM:  blen = TERM_LEN;
      OP_XACT:  blen = cmd_ff.data_in ? cmd_ff.len + XDATA_HDR : 8'h00; // [R14]
      default:  blen = 8'h00;
    endcase
    from_fifo = 1'b0;
    cbyte     = 8'h00;
    if (st_ff == ST_HDR) begin
      case (idx_ff)
        HDR_CLA: cbyte = CLA_BYTE;
        HDR_INS: cbyte = (cmd_ff.op == OP_XACT) ? INS_XACT : INS_MANAGE;
        HDR_P1:  cbyte = p1;
        HDR_P2:  cbyte = p2;
        default: cbyte = p3;
      endcase
    end else if (cmd_ff.op == OP_START) begin
      from_fifo = (idx_ff >= IDX_ID0 && idx_ff < IDX_MAC_TAG) ||
                  (idx_ff >= IDX_MAC0 && idx_ff < IDX_SIZE_TAG); // [R5]
      case (idx_ff) // [R1]
        IDX_TAG:      cbyte = TAG_CMD;
        IDX_LEN:      cbyte = START_TLV_LEN;
        IDX_SEL_TAG:  cbyte = TAG_SEL;
        IDX_SEL_LEN:  cbyte = LEN_SEL;
        IDX_UCA:      cbyte = cmd_ff.cipher_algorithm_byte;
        IDX_UIM:      cbyte = cmd_ff.integrity_mechanism_byte;
        IDX_ID_TAG:   cbyte = TAG_CONN;
        IDX_ID_LEN:   cbyte = LEN_ID; // [R5]
        IDX_MAC_TAG:  cbyte = TAG_MAC;
        IDX_MAC_LEN:  cbyte = LEN_ID; // [R5]
        IDX_SIZE_TAG: cbyte = TAG_SIZE;
        IDX_SIZE_LEN: cbyte = LEN_SIZE;
        default:      cbyte = cmd_ff.size;
      endcase
    end else if (cmd_ff.op == OP_TERM) begin
      // One association TLV per command keeps the list trivially consistent
      from_fifo = (idx_ff > TERM_IDX_LEN); // [R12] [R13]
      case (idx_ff)
        IDX_TAG:      cbyte = TAG_CMD; // [R11]
        IDX_LEN:      cbyte = TERM_TLV_LEN;
        TERM_IDX_TAG: cbyte = cmd_ff.master ? TAG_MASTER : TAG_CONN; // [R12]
        default:      cbyte = LEN_ASSOC; // [R13]
      endcase
    end else begin
      from_fifo = (idx_ff > IDX_LEN);
      cbyte     = (idx_ff == IDX_TAG) ? TAG_XDATA : cmd_ff.len;
    end
    cur_byte = from_fifo ? f_data : cbyte;
  end

  // Sequencer and response capture
  always_comb begin
    nxt_st    = st_ff;
    nxt_cmd   = cmd_ff;
    nxt_idx   = idx_ff;
    nxt_sw1   = sw1_ff;
    nxt_swh   = swh_ff;
    nxt_rxi   = rxi_ff;
    nxt_rsess = rsess_ff;
    nxt_rgot  = rgot_ff;
    nxt_sts   = sts_ff;
    nxt_rd    = rd_ff;
    nxt_err   = 1'b0;
    nxt_rv    = 1'b0;
    nxt_done  = 1'b0;
    nxt_txv   = txv_ff && !tx_ready;
    nxt_txd   = txd_ff;
    nxt_txl   = txl_ff;
    if (adv) begin
      nxt_txv = 1'b1;
      nxt_txd = cur_byte;
      nxt_txl = 1'b0;
    end
    case (st_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_cmd         = cmd;
          nxt_cmd.data_in = cmd.data_in && !cmd.abort; // [R14]
          nxt_st          = ST_HDR;
          nxt_idx         = 8'h00;
        end else if (cmd_valid) begin
          nxt_err = 1'b1;
        end
      end
      ST_HDR: begin
        if (adv) begin
          nxt_idx = idx_ff + 8'h01;
          if (last_hdr) begin
            nxt_idx = 8'h00;
            nxt_st  = (idx_ff == HDR_P3 && blen != 8'h00) ? ST_BODY : ST_RX;
            nxt_txl = !(idx_ff == HDR_P3 && blen != 8'h00);
          end
        end
      end
      ST_BODY: begin
        if (adv) begin
          nxt_idx = idx_ff + 8'h01;
          if (idx_ff == blen - 8'h01) begin
            nxt_st  = ST_RX;
            nxt_txl = 1'b1;
          end
        end
      end
      ST_RX: begin
        if (rx_valid && rx_is_sw && !swh_ff) begin
          nxt_sw1 = rx_data;
          nxt_swh = 1'b1;
        end else if (sw_fire) begin
          nxt_sts.sw1       = sw1_ff;
          nxt_sts.sw2       = rx_data;
          nxt_sts.ok        = (sw_word == SW_OK) || (sw1_ff == SW1_XACT); // [R10] [R18]
          nxt_sts.more      = (sw1_ff == SW1_XACT) && rx_data[0]; // [R17] [R19] [R24]
          nxt_sts.proactive = ((sw1_ff == SW1_XACT) && rx_data[3]) ||
                              (sw1_ff == SW1_PROACT); // [R21] [R24]
          nxt_sts.retx      = (sw1_ff == SW1_XACT) && rx_data[4]; // [R24]
          nxt_sts.resp_sess = rx_data[2:1]; // [R24]
          nxt_sts.mac_err   = (sw_word == SW_MAC_ERR); // [R9]
          nxt_sts.no_mem    = (sw_word == SW_NO_MEM); // [R25]
          nxt_done          = 1'b1;
          nxt_swh           = 1'b0;
          nxt_rxi           = 8'h00;
          nxt_rgot          = 1'b0;
          nxt_st            = ST_IDLE;
        end else if (rx_valid && !rx_is_sw) begin
          nxt_rv  = 1'b1;
          nxt_rd  = rx_data;
          nxt_rxi = rxi_ff + 8'h01;
          if (rxi_ff == RESP_SESS_IDX && cmd_ff.op == OP_FETCH && !cmd_ff.fetch_term) begin
            nxt_rsess = rx_data[7:6]; // [R7]
            nxt_rgot  = 1'b1;
          end
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_ff    <= ST_IDLE;
      cmd_ff   <= '0;
      idx_ff   <= 8'h00;
      sw1_ff   <= 8'h00;
      swh_ff   <= 1'b0;
      rxi_ff   <= 8'h00;
      rsess_ff <= 2'b00;
      rgot_ff  <= 1'b0;
      sts_ff   <= '0;
      rd_ff    <= 8'h00;
      err_ff   <= 1'b0;
      rv_ff    <= 1'b0;
      done_ff  <= 1'b0;
      txv_ff   <= 1'b0;
      txd_ff   <= 8'h00;
      txl_ff   <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      cmd_ff   <= nxt_cmd;
      idx_ff   <= nxt_idx;
      sw1_ff   <= nxt_sw1;
      swh_ff   <= nxt_swh;
      rxi_ff   <= nxt_rxi;
      rsess_ff <= nxt_rsess;
      rgot_ff  <= nxt_rgot;
      sts_ff   <= nxt_sts;
      rd_ff    <= nxt_rd;
      err_ff   <= nxt_err;
      rv_ff    <= nxt_rv;
      done_ff  <= nxt_done;
      txv_ff   <= nxt_txv;
      txd_ff   <= nxt_txd;
      txl_ff   <= nxt_txl;
    end
  end

  // Session table: busy set on take; open set, busy cleared on status, never in the same cycle
  always_comb begin
    nxt_open = open_ff;
    nxt_busy = busy_ff;
    nxt_size = size_ff;
    nxt_pend = pend_ff;
    if (take && cmd.op == OP_START) begin
      nxt_pend = cmd.size;
    end
    if (take && cmd.op == OP_XACT && !cmd.abort) begin
      nxt_busy[cmd.sess] = 1'b1; // [R15]
    end
    if (sw_fire && cmd_ff.op == OP_FETCH && !cmd_ff.fetch_term && rgot_ff &&
        sw_word == SW_OK) begin
      nxt_open[rsess_ff] = 1'b1;
      nxt_size[rsess_ff] = pend_ff; // [R8]
      nxt_busy[rsess_ff] = 1'b0;
    end
    if (sw_fire && cmd_ff.op == OP_XACT) begin
      if (cmd_ff.abort || sw_word == SW_NO_MEM) begin
        nxt_busy[cmd_ff.sess] = 1'b0; // [R20] [R25]
      end else if (sw1_ff == SW1_XACT && !rx_data[0]) begin
        nxt_busy[rx_data[2:1]] = 1'b0; // [R24]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      open_ff <= 4'h0;
      busy_ff <= 4'h0;
      size_ff <= '{default: 8'h00};
      pend_ff <= 8'h00;
    end else begin
      open_ff <= nxt_open;
      busy_ff <= nxt_busy;
      size_ff <= nxt_size;
      pend_ff <= nxt_pend;
    end
  end

  sequence s_body(hsc_op_t o, logic [7:0] i);
    st_ff == ST_BODY && adv && cmd_ff.op == o && idx_ff == i;
  endsequence
  sequence s_abort_p2;
    st_ff == ST_HDR && adv && cmd_ff.op == OP_XACT && cmd_ff.abort && idx_ff == HDR_P2;
  endsequence

  a_sel_onehot: assert property (s_body(OP_START, IDX_UCA) |=> $onehot(tx_data) ##1 // [R3]
    (!tx_valid || $onehot(tx_data))) else $error("selector byte not one-hot");
  a_start_mac_tag: assert property (s_body(OP_START, IDX_MAC_TAG) |=> // [R1]
    tx_data == TAG_MAC) else $error("start MAC tag wrong");
  a_id_len: assert property (s_body(OP_START, IDX_ID_LEN) |=> tx_data == LEN_ID) // [R5]
    else $error("association id length wrong");
  a_term_len: assert property (s_body(OP_TERM, TERM_IDX_LEN) |=> tx_data == LEN_ASSOC) // [R13]
    else $error("association TLV length wrong");
  a_size_limit: assert property (st_ff == ST_IDLE && cmd_valid && cmd.op == OP_START && // [R6]
    cmd.size > card_max_size |=> cmd_err && st_ff == ST_IDLE) else $error("oversize accepted");
  a_abort_short: assert property (s_abort_p2 |=> st_ff == ST_RX && tx_last && // [R14]
    tx_data == cmd_ff.blocks) else $error("abort sent more than header");
  a_out_le: assert property (st_ff == ST_HDR && adv && cmd_ff.op == OP_XACT && // [R22]
    !cmd_ff.data_in && !cmd_ff.abort && idx_ff == HDR_P3 |=> tx_data == cmd_ff.len
    && st_ff == ST_RX) else $error("outgoing case Le wrong");
  a_mac_flag: assert property (sw_fire && sw_word == SW_MAC_ERR |=> done && // [R9]
    sts.mac_err && !sts.ok ##1 !done) else $error("MAC error not reported");
  a_memfail_clear: assert property (sw_fire && cmd_ff.op == OP_XACT && // [R25]
    sw_word == SW_NO_MEM |=> !xfer_busy[cmd_ff.sess] && sts.no_mem)
    else $error("session not aborted on no memory");
  a_bind_size: assert property (sw_fire && cmd_ff.op == OP_FETCH && !cmd_ff.fetch_term // [R8]
    && rgot_ff && sw_word == SW_OK |=> sess_open[rsess_ff] && size_ff[rsess_ff] == pend_ff)
    else $error("session not bound to size");
endmodule

// ---- hdl/hsc_pkg.sv ----
// Constants and types of the terminal-side secure channel controller
package hsc_pkg;
  localparam logic [7:0] CLA_BYTE      = 8'h80; // Arbitrary class byte
  localparam logic [7:0] INS_MANAGE    = 8'h73; // Arbitrary instruction code
  localparam logic [7:0] INS_XACT      = 8'h75; // Arbitrary instruction code
  localparam logic [7:0] P1_START      = 8'h03;
  localparam logic [7:0] P1_TERM       = 8'h04;
  localparam logic [7:0] P2_CMD        = 8'h80;
  localparam logic [7:0] P2_RESP       = 8'ha0;
  localparam logic [7:0] TAG_CMD       = 8'h73;
  localparam logic [7:0] TAG_RESP      = 8'h53;
  localparam logic [7:0] TAG_SEL       = 8'h89;
  localparam logic [7:0] TAG_MASTER    = 8'h88;
  localparam logic [7:0] TAG_CONN      = 8'h8b;
  localparam logic [7:0] TAG_MAC       = 8'h8d;
  localparam logic [7:0] TAG_SIZE      = 8'h8e;
  localparam logic [7:0] TAG_XDATA     = 8'h80;
  localparam logic [7:0] LEN_SEL       = 8'h02;
  localparam logic [7:0] LEN_ID        = 8'h10;
  localparam logic [7:0] LEN_SIZE      = 8'h01;
  localparam logic [7:0] LEN_ASSOC     = 8'h20;
  localparam logic [7:0] START_TLV_LEN = 8'h2b;
  localparam logic [7:0] START_LC      = 8'h2d;
  localparam logic [7:0] TERM_TLV_LEN  = 8'h22;
  localparam logic [7:0] TERM_LC       = 8'h24;
  localparam logic [7:0] XDATA_MAX     = 8'h7f;
  localparam logic [7:0] XDATA_HDR     = 8'h02;
  localparam logic [7:0] SEL_RSVD_MASK = 8'h78;
  localparam logic [7:0] SW1_XACT      = 8'h92;
  localparam logic [7:0] SW1_PROACT    = 8'h91;
  localparam logic [15:0] SW_OK        = 16'h9000;
  localparam logic [15:0] SW_MAC_ERR   = 16'h9862;
  localparam logic [15:0] SW_NO_MEM    = 16'h6a84;
  // Byte positions in header and payloads
  localparam logic [7:0] HDR_CLA = 8'h00, HDR_INS = 8'h01, HDR_P1 = 8'h02;
  localparam logic [7:0] HDR_P2 = 8'h03, HDR_P3 = 8'h04;
  localparam logic [7:0] IDX_TAG = 8'h00, IDX_LEN = 8'h01, IDX_SEL_TAG = 8'h02;
  localparam logic [7:0] IDX_SEL_LEN = 8'h03, IDX_UCA = 8'h04, IDX_UIM = 8'h05;
  localparam logic [7:0] IDX_ID_TAG = 8'h06, IDX_ID_LEN = 8'h07, IDX_ID0 = 8'h08;
  localparam logic [7:0] IDX_MAC_TAG = 8'h18, IDX_MAC_LEN = 8'h19, IDX_MAC0 = 8'h1a;
  localparam logic [7:0] IDX_SIZE_TAG = 8'h2a, IDX_SIZE_LEN = 8'h2b;
  localparam logic [7:0] START_LEN = 8'h2d;
  localparam logic [7:0] TERM_IDX_TAG = 8'h02, TERM_IDX_LEN = 8'h03, TERM_LEN = 8'h24;
  localparam logic [7:0] RESP_SESS_IDX = 8'h02;
  localparam int NUM_SESS = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int BYTE_W = 8;

  typedef enum logic [1:0] {
    OP_START = 2'b00, OP_TERM = 2'b01, OP_FETCH = 2'b10, OP_XACT = 2'b11
  } hsc_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_HDR = 2'b01, ST_BODY = 2'b10, ST_RX = 2'b11
  } hsc_state_t;

  typedef struct packed {
    hsc_op_t    op;
    logic [1:0] sess;
    logic       data_in;
    logic       abort;
    logic       retx;
    logic       fetch_term;
    logic       master;
    logic [7:0] blocks;
    logic [7:0] len;
    logic [7:0] cipher_algorithm_byte;
    logic [7:0] integrity_mechanism_byte;
    logic [7:0] size;
  } hsc_cmd_t;

  typedef struct packed {
    logic [7:0] sw1;
    logic [7:0] sw2;
    logic       ok;
    logic       more;
    logic       proactive;
    logic       retx;
    logic [1:0] resp_sess;
    logic       mac_err;
    logic       no_mem;
  } hsc_sts_t;
endpackage

// ---- tb/hsc_card_model.sv ----
// Card-side behavioural model answering the controller's command units
module hsc_card_model
  import hsc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_is_sw
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] b[$];
  logic [7:0] q[$];
  logic [1:0] nsess;
  logic [7:0] p1;
  assign tx_ready = 1'b1;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_is_sw = 1'b0;
  end
  task automatic send(input logic [7:0] d, input logic sw);
    repeat (slow ? 4 : 1) @(posedge core_clk);
    #1;
    rx_valid = 1'b1;
    rx_data  = d;
    rx_is_sw = sw;
    @(posedge core_clk);
    #1;
    rx_valid = 1'b0;
    // Released line shows inverse, never the stale byte
    rx_data  = ~d;
    rx_is_sw = 1'b0;
  endtask
  task automatic answer();
    logic [15:0] sw;
    q.delete();
    p1 = b[2];
    sw = SW_OK;
    if (b[1] == INS_MANAGE && p1 == P1_START && b[3] == P2_CMD) begin
      // Malformed start gets an error and opens nothing
      if (b.size() != 50 || b[4] != START_LC || b[5] != TAG_CMD || b[7] != TAG_SEL
          || b[11] != TAG_CONN || b[12] != LEN_ID || b[29] != TAG_MAC || b[47] != TAG_SIZE
          || !$onehot(b[9]) || !$onehot(b[10]) || |((b[9] | b[10]) & SEL_RSVD_MASK))
        sw = 16'h6a80;
    end else if (b[1] == INS_MANAGE && p1 == P1_START) begin
      q = '{TAG_RESP, 8'h01, {nsess, 6'h00}};
      nsess = nsess + 2'h1;
    end else if (b[1] == INS_MANAGE && b[3] == P2_RESP) begin
      // No terminate response data, so report a pending proactive command
      sw = {SW1_PROACT, 8'h10};
    end else if (b[1] == INS_MANAGE) begin
      if (b[3] != P2_CMD || b[5] != TAG_CMD || b[8] != LEN_ASSOC)
        sw = 16'h6a80;
      else if (b[25] == 8'hff)
        sw = SW_MAC_ERR;
    end else if (p1[1]) begin
      sw = SW_OK;
    end else if (p1[2]) begin
      // Small buffer so memory exhaustion is reachable
      if (b[6] > 8'h0c)
        sw = SW_NO_MEM;
      // Boundary length asks for a resend and flags proactive
      else if (b[6] == 8'h0c)
        sw = {SW1_XACT, 3'h0, 2'h3, p1[7:6], 1'b0};
      else
        sw = {SW1_XACT, 5'h00, p1[7:6], 1'b0};
    end else begin
      q = '{TAG_XDATA, 8'h01, 8'ha5};
      sw = {SW1_XACT, 5'h00, p1[7:6], 1'b1};
    end
    foreach (q[i]) send(q[i], 1'b0);
    send(sw[15:8], 1'b1);
    send(sw[7:0], 1'b1);
  endtask
  always @(posedge core_clk) begin
    if (reset) begin
      b.delete();
      nsess = 2'h0;
    end else if (tx_valid) begin
      b.push_back(tx_data);
      if (tx_last) begin
        answer();
        b.delete();
      end
    end
  end
endmodule

// ---- tb/hsc_host_tb.sv ----
// Self-checking bench for the terminal-side secure channel controller
module hsc_host_tb
  import hsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, e) begin \
    comparisons++; \
    if ((a) !== (e)) begin \
      bad_count++; \
      $display("[ERR] %0t got %h want %h", $time, (a), (e)); \
    end \
  end
  logic       core_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, pay_valid = 1'b0, slow = 1'b0;
  logic [7:0] pay_data = 8'h00, card_max_size = 8'h10, tx_data, rx_data, resp_data, last_resp;
  logic       cmd_ready, cmd_err, pay_ready, tx_valid, tx_last, tx_ready, got_err;
  logic       rx_valid, rx_is_sw, resp_valid, done;
  logic [3:0] sess_open, xfer_busy;
  hsc_cmd_t   cmd = '0;
  hsc_cmd_t   bad[5], ord;
  hsc_sts_t   sts;
  int         bad_count = 0, comparisons = 0, nresp = 0, cyc = 0;
  logic [7:0] sel[4] = '{8'h01, 8'h02, 8'h04, 8'h80};
  hsc_host dut (.core_clk, .reset, .cmd_valid, .cmd_ready, .cmd, .cmd_err, .pay_valid,
    .pay_ready, .pay_data, .card_max_size, .tx_valid, .tx_ready, .tx_data, .tx_last,
    .rx_valid, .rx_data, .rx_is_sw, .resp_valid, .resp_data, .done, .sts, .sess_open,
    .xfer_busy);
  hsc_card_model card (.core_clk, .reset, .slow, .tx_valid, .tx_data, .tx_last, .tx_ready,
    .rx_valid, .rx_data, .rx_is_sw);
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (resp_valid === 1'b1) begin
      nresp++;
      last_resp = resp_data;
    end
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic hsc_cmd_t mk(hsc_op_t op, logic [1:0] s, logic [2:0] f,
                                  logic [7:0] bl, ln, ca, im, sz);
    mk = '0;
    mk.op = op;
    mk.sess = s;
    {mk.data_in, mk.abort, mk.master} = f;
    mk.blocks = bl;
    mk.len = ln;
    mk.cipher_algorithm_byte = ca;
    mk.integrity_mechanism_byte = im;
    mk.size = sz;
  endfunction
  // Order and its payload run side by side: 32-byte payloads exceed the 16-deep buffer
  task automatic go(input hsc_cmd_t c, input int n, input logic [7:0] base);
    @(posedge core_clk);
    #1;
    nresp = 0;
    fork
      begin
        pay_valid = (n > 0);
        for (int i = 0; i < n; i++) begin
          pay_data = base + 8'(i);
          @(negedge core_clk);
          while (pay_ready !== 1'b1) @(negedge core_clk);
          @(posedge core_clk);
          #1;
        end
        pay_valid = 1'b0;
      end
      begin
        cmd = c;
        cmd_valid = 1'b1;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        for (int k = 0; k < 4000 && done !== 1'b1 && cmd_err !== 1'b1; k++) begin
          @(posedge core_clk);
          #1;
        end
        got_err = cmd_err;
      end
    join
  endtask
  initial begin
    bad[0] = mk(OP_START, 2'h0, 3'h0, 8'h00, 8'h00, 8'h03, 8'h01, 8'h10);
    bad[1] = mk(OP_START, 2'h0, 3'h0, 8'h00, 8'h00, 8'h01, 8'h08, 8'h10);
    bad[2] = mk(OP_START, 2'h0, 3'h0, 8'h00, 8'h00, 8'h01, 8'h01, 8'h11);
    bad[3] = mk(OP_XACT, 2'h0, 3'h0, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00);
    bad[4] = mk(OP_XACT, 2'h0, 3'h4, 8'h00, 8'h11, 8'h00, 8'h00, 8'h00);
    repeat (20) @(posedge core_clk);
    #1;
    reset = 1'b0;
    `CHK({cmd_ready, sess_open, xfer_busy}, 9'h100)
    for (int i = 0; i < 4; i++) begin
      slow = i[0];
      go(mk(OP_START, 2'h0, 3'h0, 8'h00, 8'h00, sel[i], sel[3-i], 8'h10), 32, 8'(i * 32));
      `CHK({got_err, sts.sw1, sts.sw2}, {1'b0, SW_OK})
      go(mk(OP_FETCH, 2'h0, 3'h0, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00), 0, 8'h00);
      `CHK({nresp[3:0], sts.ok, sess_open}, {4'h3, 1'b1, 4'(4'hf >> (3 - i))})
      `CHK(last_resp, {2'(i), 6'h00})
    end
    slow = 1'b0;
    $display("test start finished");
    foreach (bad[j]) begin
      go(bad[j], 0, 8'h00);
      `CHK(got_err, 1'b1)
    end
    $display("test refusal finished");
    go(mk(OP_TERM, 2'h0, 3'h1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00), 32, 8'h00);
    `CHK({sts.sw1, sts.sw2, sts.mac_err}, {SW_OK, 1'b0})
    go(mk(OP_TERM, 2'h0, 3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00), 32, 8'hef);
    `CHK({sts.sw1, sts.sw2, sts.mac_err}, {SW_MAC_ERR, 1'b1})
    ord = mk(OP_FETCH, 2'h0, 3'h0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    ord.fetch_term = 1'b1;
    go(ord, 0, 8'h00);
    `CHK({sts.sw1, sts.proactive, sts.ok, sess_open}, {SW1_PROACT, 6'h2f})
    $display("test terminate finished");
    go(mk(OP_XACT, 2'h0, 3'h4, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00), 2, 8'h40);
    `CHK({sts.sw1, sts.more, sts.resp_sess}, {SW1_XACT, 3'h0})
    go(mk(OP_XACT, 2'h1, 3'h4, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00), 4, 8'h50);
    `CHK({sts.sw1, sts.resp_sess, xfer_busy[1]}, {SW1_XACT, 3'h2})
    go(mk(OP_XACT, 2'h0, 3'h4, 8'h01, 8'h0c, 8'h00, 8'h00, 8'h00), 12, 8'h70);
    `CHK({sts.retx, sts.proactive, sts.ok, sts.resp_sess}, 5'h1c)
    go(mk(OP_XACT, 2'h3, 3'h4, 8'h00, 8'h0e, 8'h00, 8'h00, 8'h00), 14, 8'h60);
    `CHK({sts.no_mem, xfer_busy[3]}, 2'h2)
    go(mk(OP_XACT, 2'h2, 3'h0, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00), 0, 8'h00);
    `CHK({nresp[3:0], sts.more, xfer_busy[2]}, 6'h0f)
    `CHK(last_resp, 8'ha5)
    go(mk(OP_XACT, 2'h2, 3'h2, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00), 0, 8'h00);
    `CHK({sts.ok, xfer_busy[2], sess_open[2]}, 3'h5)
    $display("test transact finished");
    print_verdict();
  end
endmodule
